// ==== frt_map.vh ====
// Register offsets, field positions, reset values and constants of the timer block
`ifndef FRT_MAP_VH
`define FRT_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets (per channel stride below)
// ----------------------------------------------------------------
`define FRT_OFS_CTRL        12'h000
`define FRT_OFS_TRIG        12'h004
`define FRT_OFS_PERIOD      12'h008
`define FRT_OFS_COUNT       12'h00C
`define FRT_CH_STRIDE       12'h010
`define FRT_CH_SHIFT        4
`define FRT_REG_SEL_MSB     3
`define FRT_REG_SEL_LSB     2

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FRT_CTRL_RUN        0
`define FRT_CTRL_UPDOWN     1
`define FRT_CTRL_BUF_EN     7
`define FRT_CTRL_MASK       16'h0083

// ----------------------------------------------------------------
// Trigger enable fields
// ----------------------------------------------------------------
`define FRT_TRIG_MASK       16'h0007
`define FRT_TRIG_UNITS      3

// ----------------------------------------------------------------
// Reset values and special counts
// ----------------------------------------------------------------
`define FRT_PERIOD_RST      16'hFFFF
`define FRT_COUNT_RST       16'h0000
`define FRT_CTRL_RST        16'h0000
`define FRT_TRIG_RST        16'h0000
`define FRT_ZERO            16'h0000
`define FRT_MAX             16'hFFFF
`define FRT_ONE             16'h0001
`define FRT_DIV_RST         16'h0000

`endif

// ==== frt_clk_div.v ====
// Count clock enable divider
`timescale 1ns/100ps
module frt_clk_div #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire [W-1:0] div_ratio,
	output wire         tick
);
	`include "frt_map.vh"

	reg [W-1:0] cnt_reg;

	// ----------------------------------------------------------------
	// Pulse once every div_ratio+1 cycles
	// ----------------------------------------------------------------
	assign tick = (cnt_reg == div_ratio);

	always @(posedge clk) begin
		if (!rstn) begin
			cnt_reg <= {W{1'b0}};
		end else if (tick) begin
			cnt_reg <= {W{1'b0}};
		end else begin
			cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ==== frt_channel.v ====
// One timer channel: period buffer, counter and zero detection
`timescale 1ns/100ps
module frt_channel (
	input  wire        clk,
	input  wire        rstn,
	input  wire        tick,
	input  wire        run,
	input  wire        updown,
	input  wire        buf_en,
	input  wire        period_wr,
	input  wire [15:0] period_wdata,
	input  wire        count_clr,
	output reg  [15:0] period_reg,
	output reg  [15:0] count_reg,
	output reg         zero_det_reg
);
	`include "frt_map.vh"

	reg  [15:0] period_buf_reg;
	reg         down_reg;
	reg         pend_reg;
	reg  [15:0] count_next;
	reg         down_next;
	wire [15:0] buf_src;

	assign buf_src = period_wr ? period_wdata : period_buf_reg;

	// ----------------------------------------------------------------
	// Counter next value
	// ----------------------------------------------------------------
	always @* begin
		count_next = count_reg;
		down_next  = down_reg;
		if (!updown) begin
			// Up mode wraps after period: (P+1) ticks per cycle; a period below the count runs to all-ones
			if (count_reg == period_reg) begin
				count_next = `FRT_ZERO;
			end else begin
				count_next = count_reg + `FRT_ONE;
			end
			down_next = 1'b0;
		end else begin
			// Up/down: 0 up to P and back, 2*P ticks per cycle
			if (!down_reg) begin
				if (count_reg >= period_reg) begin
					count_next = count_reg - `FRT_ONE;
					down_next  = 1'b1;
				end else begin
					count_next = count_reg + `FRT_ONE;
				end
			end else begin
				count_next = count_reg - `FRT_ONE;
				if (count_next == `FRT_ZERO) begin
					down_next = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			period_buf_reg <= `FRT_PERIOD_RST;
			period_reg     <= `FRT_PERIOD_RST;
			count_reg      <= `FRT_COUNT_RST;
			down_reg       <= 1'b0;
			pend_reg       <= 1'b0;
			zero_det_reg   <= 1'b0;
		end else begin
			zero_det_reg <= 1'b0;
			if (period_wr) begin
				period_buf_reg <= period_wdata;
			end
			if (!buf_en && period_wr) begin
				period_reg <= period_wdata;
			end else if (buf_en && (period_wr || pend_reg) && !run) begin
				period_reg <= buf_src;
				pend_reg   <= 1'b0;
			end else if (buf_en && period_wr) begin
				pend_reg <= 1'b1;
			end
			if (run && tick) begin
				count_reg <= count_next;
				down_reg  <= down_next;
				if (count_next == `FRT_ZERO) begin
					zero_det_reg <= 1'b1;
					if (buf_en && (pend_reg || period_wr)) begin
						period_reg <= buf_src;
						pend_reg   <= 1'b0;
					end
				end
			end else if (count_clr && !run) begin
				count_reg <= `FRT_ZERO;
				down_reg  <= 1'b0;
			end
		end
	end
endmodule

// ==== frt_top.v ====
// Three-channel free-running timer with APB registers and converter triggers
//
// Contract
// - Trigger enable bits 0..2 route zero detection to converter units 0..2.
// - Triggers from all three channels for one unit are ORed.
// - Trigger enable bits 15:3 read zero; software writes zero.
// - Period write goes to buffer; read returns active period.
// - Up mode cycle is period plus one count clocks.
// - Up/down mode cycle is twice period count clocks.
// - Buffer disabled: written period becomes active immediately.
// - Buffer enabled: transfer only when stopped or count reaches zero.
// - Buffer enable bit in control register selects buffering.
// - Period below count with no buffer: counter runs to all-ones (in up/down mode the counter turns and counts down instead).
// - Period may be rewritten while the counter runs.
// - Count read returns the live counter value.
// - Writing zero to count clears only while stopped.
// - Zero detection only at counted zero, not start or clear.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
module frt_top #(
	parameter DIV_W = 16
) (
	input  wire             clk,
	input  wire             rstn,
	input  wire [11:0]      paddr,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [31:0]      pwdata,
	input  wire [3:0]       pstrb,
	output wire             pready,
	output reg  [31:0]      prdata,
	output wire             pslverr,
	input  wire [DIV_W-1:0] div_ratio,
	output wire [2:0]       conv_start
);
	`include "frt_map.vh"

	localparam NCH = 3;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire        acc     = psel && penable;
	wire        wr      = acc && pwrite;
	wire [1:0]  ch_idx  = paddr[`FRT_CH_SHIFT+1:`FRT_CH_SHIFT];
	wire [11:0] reg_ofs = {8'h00, paddr[`FRT_REG_SEL_MSB:0]};
	wire        ch_ok   = (ch_idx < 2'h3) && (paddr[11:`FRT_CH_SHIFT+2] == 6'h00)
	                      && (paddr[1:0] == 2'h0);
	wire        lo_hw   = pstrb[0] && pstrb[1];
	wire        hw_ok   = !pwrite || lo_hw;

	assign pready  = 1'b1;
	assign pslverr = acc && (!ch_ok || !hw_ok);

	function sel_reg;
		input [11:0] ofs;
		input [1:0]  ch;
		input integer want_ch;
		input [11:0] want_ofs;
		begin
			sel_reg = (ofs == want_ofs) && (ch == want_ch[1:0]);
		end
	endfunction

	wire [15:0] ctrl_w   [0:NCH-1];
	wire [15:0] trig_w   [0:NCH-1];
	wire [15:0] period_w [0:NCH-1];
	wire [15:0] count_w  [0:NCH-1];
	wire [NCH-1:0] zero_w;
	wire        tick;

	frt_clk_div #(
		.W (DIV_W)
	) u_div (
		.clk       (clk),
		.rstn      (rstn),
		.div_ratio (div_ratio),
		.tick      (tick)
	);

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : gch
			wire wok = wr && ch_ok && lo_hw;
			wire pwr = wok && sel_reg(reg_ofs, ch_idx, g, `FRT_OFS_PERIOD);
			wire cwr = wok && sel_reg(reg_ofs, ch_idx, g, `FRT_OFS_COUNT);
			wire clr = cwr && (pwdata[15:0] == `FRT_ZERO);
			reg  [15:0] ctrl_reg;
			reg  [15:0] trig_reg;

			assign ctrl_w[g] = ctrl_reg;
			assign trig_w[g] = trig_reg;

			always @(posedge clk) begin
				if (!rstn) begin
					ctrl_reg <= `FRT_CTRL_RST;
					trig_reg <= `FRT_TRIG_RST;
				end else begin
					if (wok && sel_reg(reg_ofs, ch_idx, g, `FRT_OFS_CTRL)) begin
						ctrl_reg <= pwdata[15:0] & `FRT_CTRL_MASK;
					end
					if (wok && sel_reg(reg_ofs, ch_idx, g, `FRT_OFS_TRIG)) begin
						trig_reg <= pwdata[15:0] & `FRT_TRIG_MASK;
					end
				end
			end

			frt_channel u_ch (
				.clk          (clk),
				.rstn         (rstn),
				.tick         (tick),
				.run          (ctrl_reg[`FRT_CTRL_RUN]),
				.updown       (ctrl_reg[`FRT_CTRL_UPDOWN]),
				.buf_en       (ctrl_reg[`FRT_CTRL_BUF_EN]),
				.period_wr    (pwr),
				.period_wdata (pwdata[15:0]),
				.count_clr    (clr),
				.period_reg   (period_w[g]),
				.count_reg    (count_w[g]),
				.zero_det_reg (zero_w[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Converter triggers, ORed over channels per unit
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < `FRT_TRIG_UNITS; g = g + 1) begin : gunit
			assign conv_start[g] = (zero_w[0] & trig_w[0][g]) |
			                       (zero_w[1] & trig_w[1][g]) |
			                       (zero_w[2] & trig_w[2][g]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite && ch_ok) begin
			case (reg_ofs)
				`FRT_OFS_CTRL:   prdata <= {16'h0000, ctrl_w[ch_idx]};
				`FRT_OFS_TRIG:   prdata <= {16'h0000, trig_w[ch_idx]};
				`FRT_OFS_PERIOD: prdata <= {16'h0000, period_w[ch_idx]};
				`FRT_OFS_COUNT:  prdata <= {16'h0000, count_w[ch_idx]};
				default:         prdata <= 32'h00000000;
			endcase
		end else if (psel && !penable) begin
			prdata <= 32'h00000000;
		end
	end
endmodule

// ==== frt_checker.sv ====
// Port-level assertions for the three-channel timer block
`timescale 1ns/100ps
module frt_checker #(
	parameter DIV_W = 16
) (
	input wire             clk,
	input wire             rstn,
	input wire [11:0]      paddr,
	input wire             psel,
	input wire             penable,
	input wire             pwrite,
	input wire [31:0]      pwdata,
	input wire [3:0]       pstrb,
	input wire             pready,
	input wire [31:0]      prdata,
	input wire             pslverr,
	input wire [DIV_W-1:0] div_ratio,
	input wire [2:0]       conv_start
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_rd;
		psel && penable && !pwrite;
	endsequence
	chk_ready_tied: assert property (pready) else $error("pready low");
	chk_trig_pulse: assert property ((conv_start & $past(conv_start)) == 3'h0) else $error("trigger too long");
	chk_trig_reset: assert property (disable iff (1'b0) !rstn |=> conv_start == 3'h0) else $error("trigger in reset");
	chk_resv_zero: assert property (s_rd and paddr[3:0] == 4'h4 |-> prdata[31:3] == 29'h0) else $error("reserved set");
	chk_half_zero: assert property (s_rd |-> prdata[31:16] == 16'h0) else $error("upper half set");
	chk_err_align: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
	chk_err_chan: assert property (psel && penable && paddr[11:4] > 8'h2 |-> pslverr) else $error("no error");
	chk_err_data: assert property (s_rd and pslverr |-> prdata == 32'h0) else $error("error data");
	chk_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
	chk_rd_stable: assert property (s_setup ##1 s_rd |=> $stable(prdata)) else $error("read data moved");
endmodule
bind frt_top frt_checker #(.DIV_W(DIV_W)) u_chk (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .div_ratio(div_ratio), .conv_start(conv_start));

// ==== frt_adc_model.sv ====
// Model of the three converter units counting start pulses
`timescale 1ns/100ps
module frt_adc_model (
	input  wire        clk,
	input  wire        rstn,
	input  wire [2:0]  conv_start,
	output reg  [23:0] hits,
	output reg  [15:0] gap0
);
	reg [15:0] since;
	integer    i;
	always @(posedge clk) begin
		if (!rstn) begin
			hits  <= 24'h0;
			gap0  <= 16'h0;
			since <= 16'h0;
		end else begin
			since <= since + 16'h1;
			for (i = 0; i < 3; i = i + 1)
				if (conv_start[i]) hits[8*i+:8] <= hits[8*i+:8] + 8'h1;
			if (conv_start[0]) begin
				gap0  <= since + 16'h1;
				since <= 16'h0;
			end
		end
	end
endmodule

// ==== frt_top_tb_top.sv ====
// Self-checking bench for the three-channel timer block
`timescale 1ns/100ps
module frt_top_tb_top;
	reg         clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, re;
	reg  [11:0] paddr = 12'h0, b;
	reg  [31:0] pwdata = 32'h0, rv, v;
	reg  [3:0]  pstrb = 4'hF, div_ratio = 4'h0;
	reg  [23:0] h;
	wire        pready, pslverr;
	wire [31:0] prdata;
	wire [2:0]  conv_start;
	wire [23:0] hits;
	wire [15:0] gap0;
	integer     n_mismatch = 0, checks = 0, cyc = 0, c, j, k, u;
	always #2 clk = ~clk;
	frt_top #(.DIV_W(4)) DUT (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .div_ratio(div_ratio), .conv_start(conv_start));
	frt_adc_model u_adc (.clk(clk), .rstn(rstn), .conv_start(conv_start), .hits(hits), .gap0(gap0));
	task print_verdict;
		begin
			$display("mismatches %0d checks %0d", n_mismatch, checks);
			if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task xfer(input [11:0] a, input wr, input [15:0] d);
		begin
			@(posedge clk);
			paddr <= a; pwrite <= wr; pwdata <= {16'h0, d}; psel <= 1'b1;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (!pready) @(posedge clk);
			rv = prdata; re = pslverr;
			psel <= 1'b0; penable <= 1'b0;
		end
	endtask
	task wr(input [11:0] a, input [15:0] d); xfer(a, 1'b1, d); endtask
	task rdc(input [11:0] a, input [31:0] e); begin xfer(a, 1'b0, 16'h0); chk(rv, e); end endtask
	task wt(input integer n); repeat (n) @(posedge clk); endtask
	task t_units;
		for (c = 0; c < 3; c = c + 1) for (j = 0; j < 2; j = j + 1) begin
			u = (c + j) % 3; b = c * 16;
			wr(b + 8, 16'h3); wr(b + 4, 16'h1 << u); h = hits;
			wr(b, 16'h1); wt(20); wr(b, 16'h0); wr(b + 12, 16'h0);
			for (k = 0; k < 3; k = k + 1) chk(hits[8*k+:8] != h[8*k+:8], k == u);
		end
	endtask
	task t_modes;
		begin
			wr(12'h4, 16'h1); wr(12'h8, 16'h3); wr(12'h0, 16'h1); wt(30); chk(gap0, 4);
			wr(12'h8, 16'h2); rdc(12'h8, 2); wt(30); chk(gap0, 3);
			wr(12'h0, 16'h81); wr(12'h8, 16'h5); rdc(12'h8, 2);
			wt(30); rdc(12'h8, 5); chk(gap0, 6);
			wr(12'h0, 16'h80); wr(12'h8, 16'h3); rdc(12'h8, 3);
			wr(12'hC, 16'h0); wr(12'h0, 16'h83); wt(40); chk(gap0, 6);
			div_ratio <= 4'h1;
			wt(40);
			chk(gap0, 12);
			div_ratio <= 4'h0;
			wr(12'h0, 16'h0);
		end
	endtask
	task t_clear;
		begin
			xfer(12'hC, 1'b0, 16'h0); v = rv; wr(12'hC, 16'h5); rdc(12'hC, v);
			h = hits; wr(12'hC, 16'h0); rdc(12'hC, 0); chk(hits, h);
			wr(12'h8, 16'h100); wr(12'h0, 16'h1); wr(12'hC, 16'h0);
			xfer(12'hC, 1'b0, 16'h0); chk(rv, 4);
			wr(12'h8, 16'h2); rdc(12'hC, 10);
			wr(12'h0, 16'h0); wr(12'hC, 16'h0);
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	end
	initial begin
		wt(5); rstn <= 1'b1;
		rdc(12'h0, 0); rdc(12'h4, 0); rdc(12'h8, 32'hFFFF); rdc(12'hC, 0);
		t_units; t_modes; t_clear;
		wr(12'h24, 16'hFFFF); rdc(12'h24, 7); wr(12'h24, 16'h0);
		xfer(12'h30, 1'b0, 16'h0); chk(re, 1); chk(rv, 0);
		print_verdict;
	end
endmodule
